// *** pkg/usb_ctl_consts.vh ***
// constants for the endpoint status and system clock control registers
`ifndef USB_CTL_CONSTS_VH
`define USB_CTL_CONSTS_VH
`define ADDR_W            8
`define ADDR_EP_STATUS    8'h21
`define ADDR_CLK_CTRL     8'h22
`define ADDR_IRQ_STATUS   8'h23
`define ADDR_IRQ_MASK     8'h24
`define EP_FLAG_LSB       0
`define EP_COUNT          4
`define MODE_LSB          4
`define USB_FLAG_BIT      7
`define EP_RESV_BIT       6
`define PULLUP_SWAP_BIT   2
`define CLK_GATE_BIT      3
`define BANDGAP_OFF_BIT   4
`define LEGACY_FLAG_BIT   5
`define OSC_SEL_BIT       6
`define ADJ_DIS_BIT       7
`define MODE_OFF          2'h0
`define MODE_WEAK         2'h1
`define MODE_USB          2'h2
`define MODE_ON           2'h3
`define EP_STATUS_RESET   8'h00
`define CLK_CTRL_RESET    8'h00
`define CLK_CTRL_WMASK    8'hfc
`define EP_STATUS_WMASK   8'hbf
`endif

// *** src/ep_flag_bit.v ***
// one sticky endpoint request flag: engine set wins over firmware clear
`timescale 1ns/1ps
`default_nettype none
module ep_flag_bit (
  // clock and reset
  input  wire clk_i,
  input  wire resetn_i,
  // set, write
  input  wire set_i,
  input  wire wr_i,
  input  wire wdata_i,
  // state
  output wire flag_o
);
  reg flag_ff;
  wire nxt_flag;
  assign nxt_flag = set_i ? 1'b1 : (wr_i ? wdata_i : flag_ff);
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end
  assign flag_o = flag_ff;
endmodule // ep_flag_bit
`default_nettype wire

// *** src/pin_sync.v ***
// two-flop synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock and reset
  input  wire clk_i,
  input  wire resetn_i,
  // async in, synced out
  input  wire d_i,
  output wire q_o
);
  reg s1_ff;
  reg s2_ff;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
    end
  end
  assign q_o = s2_ff;
endmodule // pin_sync
`default_nettype wire

// *** src/usb_status_and_clock_control_regs.v ***
// endpoint status / mode and system clock control register bank
`include "usb_ctl_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module usb_status_and_clock_control_regs #(
  parameter NUM_EP = `EP_COUNT
) (
  // clock and reset
  input  wire                clk_i,
  input  wire                resetn_i,
  // register port
  input  wire [`ADDR_W-1:0]  addr_i,
  input  wire [7:0]          wdata_i,
  input  wire                wr_i,
  input  wire                rd_i,
  output wire [7:0]          rdata_o,
  // serial interface engine
  input  wire [NUM_EP-1:0]   ep_access_i,
  // interrupt
  input  wire                usb_irq_en_i,
  input  wire                stack_full_i,
  output wire                irq_o,
  // bus data pins
  input  wire                data_plus_pin_i,
  output wire                data_plus_pin_o,
  output wire                data_plus_pin_oe_o,
  input  wire                data_minus_pin_i,
  output wire                data_minus_pin_o,
  output wire                data_minus_pin_oe_o,
  input  wire                pin_out_plus_i,
  input  wire                pin_out_minus_i,
  output wire                pin_in_plus_o,
  output wire                pin_in_minus_o,
  // analog and clock controls
  output wire                regulator_output_o,
  output wire                regulator_weak_o,
  output wire                pullup_1k5_o,
  output wire                pullup_swap_ctl_o,
  output wire                bus_clock_gate_o,
  output wire                bandgap_shutdown_o,
  output wire                legacy_port_mode_marker_o,
  output wire                usb_mode_marker_o,
  output wire                osc_freq_select_o,
  output wire                clk_adjust_disable_o
);
  // ==========================================================
  // decode
  wire wr_ep   = wr_i && (addr_i == `ADDR_EP_STATUS);
  wire wr_clk  = wr_i && (addr_i == `ADDR_CLK_CTRL);
  wire wr_ist  = wr_i && (addr_i == `ADDR_IRQ_STATUS);
  wire wr_imsk = wr_i && (addr_i == `ADDR_IRQ_MASK);

  // ==========================================================
  // endpoint request flags
  wire [NUM_EP-1:0] ep_flag;
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g = g + 1) begin : g_ep
      ep_flag_bit u_flag (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .set_i    (ep_access_i[g]),
        .wr_i     (wr_ep),
        .wdata_i  (wdata_i[`EP_FLAG_LSB+g]),
        .flag_o   (ep_flag[g])
      );
    end
  endgenerate

  // ==========================================================
  // mode field and usb marker
  reg [1:0] mode_ff;
  reg       usb_flag_ff;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_ff     <= `MODE_OFF;
      usb_flag_ff <= 1'b0;
    end else if (wr_ep) begin
      mode_ff     <= wdata_i[`MODE_LSB+1:`MODE_LSB];
      usb_flag_ff <= wdata_i[`USB_FLAG_BIT];
    end
  end

  // ==========================================================
  // system clock control
  reg [7:0] clk_ctrl_ff;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_ctrl_ff <= `CLK_CTRL_RESET;
    end else if (wr_clk) begin
      clk_ctrl_ff <= wdata_i & `CLK_CTRL_WMASK;
    end
  end
  assign pullup_swap_ctl_o         = clk_ctrl_ff[`PULLUP_SWAP_BIT];
  assign bus_clock_gate_o          = clk_ctrl_ff[`CLK_GATE_BIT];
  assign bandgap_shutdown_o        = clk_ctrl_ff[`BANDGAP_OFF_BIT];
  assign legacy_port_mode_marker_o = clk_ctrl_ff[`LEGACY_FLAG_BIT];
  assign osc_freq_select_o         = clk_ctrl_ff[`OSC_SEL_BIT];
  assign clk_adjust_disable_o      = clk_ctrl_ff[`ADJ_DIS_BIT];
  assign usb_mode_marker_o         = usb_flag_ff;

  // ==========================================================
  // mode effects on regulator and pins
  wire usb_mode = (mode_ff == `MODE_USB);
  assign regulator_output_o = usb_mode || (mode_ff == `MODE_ON);
  assign regulator_weak_o   = (mode_ff == `MODE_WEAK);
  assign pullup_1k5_o       = usb_mode && !clk_ctrl_ff[`PULLUP_SWAP_BIT];

  reg pout_p_ff;
  reg pout_m_ff;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pout_p_ff <= 1'b0;
      pout_m_ff <= 1'b0;
    end else begin
      pout_p_ff <= pin_out_plus_i;
      pout_m_ff <= pin_out_minus_i;
    end
  end
  assign data_plus_pin_o     = pout_p_ff;
  assign data_minus_pin_o    = pout_m_ff;
  assign data_plus_pin_oe_o  = !usb_mode;
  assign data_minus_pin_oe_o = !usb_mode;

  pin_sync u_sync_p (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      (data_plus_pin_i),
    .q_o      (pin_in_plus_o)
  );
  pin_sync u_sync_m (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      (data_minus_pin_i),
    .q_o      (pin_in_minus_o)
  );

  // ==========================================================
  // interrupt: sticky status, write one to clear, mask
  reg [NUM_EP-1:0] ist_ff;
  reg [NUM_EP-1:0] imsk_ff;
  wire [NUM_EP-1:0] nxt_ist =
    ep_access_i | (ist_ff & ~(wr_ist ? wdata_i[NUM_EP-1:0] : {NUM_EP{1'b0}}));
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ist_ff  <= {NUM_EP{1'b0}};
      imsk_ff <= {NUM_EP{1'b0}};
    end else begin
      ist_ff <= nxt_ist;
      if (wr_imsk) begin
        imsk_ff <= wdata_i[NUM_EP-1:0];
      end
    end
  end
  assign irq_o = |(ist_ff & imsk_ff) && usb_irq_en_i && !stack_full_i;

  // ==========================================================
  // read port
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;
  always @* begin
    nxt_rdata = 8'h00;
    case (addr_i)
      `ADDR_EP_STATUS: begin
        nxt_rdata[NUM_EP-1:0]          = ep_flag;
        nxt_rdata[`MODE_LSB+1:`MODE_LSB] = mode_ff;
        nxt_rdata[`USB_FLAG_BIT]        = usb_flag_ff;
      end
      `ADDR_CLK_CTRL:   nxt_rdata = clk_ctrl_ff;
      `ADDR_IRQ_STATUS: nxt_rdata[NUM_EP-1:0] = ist_ff;
      `ADDR_IRQ_MASK:   nxt_rdata[NUM_EP-1:0] = imsk_ff;
      default:          nxt_rdata = 8'h00;
    endcase
  end
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_i) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end
  assign rdata_o = rdata_ff;
endmodule // usb_status_and_clock_control_regs
`default_nettype wire

// *** tb/ep_engine_model.sv ***
// engine stand-in: one-cycle endpoint access pulses
`timescale 1ns/1ps
`default_nettype none
module ep_engine_model (
  // clock and command
  input  wire logic       clk_i,
  input  wire logic       hit_i,
  input  wire logic [1:0] ep_i,
  // access pulses
  output var  logic [3:0] ep_access_o = 4'h0
);
  // ==========
  // pulse
  always @(posedge clk_i) begin
    ep_access_o <= hit_i ? 4'h1 << ep_i : 4'h0;
  end
endmodule // ep_engine_model
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the register bank
`include "usb_ctl_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========
  // signals
  logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, hit_i = 0;
  logic usb_irq_en_i = 1, stack_full_i = 0;
  logic data_plus_pin_i = 0, data_minus_pin_i = 0;
  logic pin_out_plus_i = 0, pin_out_minus_i = 0;
  logic [7:0] addr_i = 0, wdata_i = 0, d, m_ep;
  logic [1:0] ep_i = 0;
  wire [3:0] ep_access_i;
  wire [7:0] rdata_o;
  wire irq_o, data_plus_pin_o, data_plus_pin_oe_o, data_minus_pin_o;
  wire data_minus_pin_oe_o, pin_in_plus_o, pin_in_minus_o, pullup_1k5_o;
  wire regulator_output_o, regulator_weak_o, pullup_swap_ctl_o;
  wire bus_clock_gate_o, bandgap_shutdown_o, legacy_port_mode_marker_o;
  wire usb_mode_marker_o, osc_freq_select_o, clk_adjust_disable_o;
  int error_cnt = 0, n_tests = 0;
  always #12.5 clk_i = ~clk_i;
  usb_status_and_clock_control_regs dut (.*);
  ep_engine_model eng (.clk_i, .hit_i, .ep_i, .ep_access_o(ep_access_i));
  // ==========
  // tasks
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i <= 1;
    @(posedge clk_i);
    rd_i <= 0;
    #1 chk(rdata_o, e);
    @(posedge clk_i);
  endtask
  task fire(input int e);
    ep_i <= e[1:0];
    hit_i <= 1;
    @(posedge clk_i);
    hit_i <= 0;
  endtask
  task finish_test;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    #20us error_cnt++;
    finish_test;
  end
  initial begin
    void'($urandom(54));
    repeat (20) @(posedge clk_i);
    resetn_i <= 1;
    @(posedge clk_i);
    rd(`ADDR_EP_STATUS, `EP_STATUS_RESET);
    rd(`ADDR_CLK_CTRL, `CLK_CTRL_RESET);
    repeat (6) begin
      d = $urandom;
      wr(`ADDR_CLK_CTRL, d);
      chk({clk_adjust_disable_o, osc_freq_select_o, legacy_port_mode_marker_o,
           bandgap_shutdown_o, bus_clock_gate_o, pullup_swap_ctl_o},
          d[7:2]);
      rd(`ADDR_CLK_CTRL, d & `CLK_CTRL_WMASK);
    end
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    for (int m = 0; m < 4; m++) begin
      d = $urandom & 8'hc0 | m << 4;
      wr(`ADDR_EP_STATUS, d);
      m_ep = d & `EP_STATUS_WMASK;
      chk({usb_mode_marker_o, regulator_output_o, regulator_weak_o,
           data_plus_pin_oe_o, data_minus_pin_oe_o},
          {d[7], m[1], m == 1, m != 2, m != 2});
      rd(`ADDR_EP_STATUS, m_ep);
    end
    wr(`ADDR_EP_STATUS, 8'h20);
    wr(`ADDR_CLK_CTRL, 8'h00);
    chk(pullup_1k5_o, 1);
    wr(`ADDR_CLK_CTRL, 8'h04);
    chk(pullup_1k5_o, 0);
    wr(`ADDR_CLK_CTRL, 8'h88);
    chk(bus_clock_gate_o, 1);
    rd(`ADDR_CLK_CTRL, 8'h88);
    wr(`ADDR_EP_STATUS, m_ep);
    pin_out_plus_i <= 1;
    pin_out_minus_i <= 0;
    data_plus_pin_i <= 0;
    data_minus_pin_i <= 1;
    repeat (3) @(posedge clk_i);
    #1 chk({data_plus_pin_o, data_minus_pin_o, pin_in_plus_o, pin_in_minus_o},
           8'h09);
    fire(0);
    @(posedge clk_i);
    chk(irq_o, 0);
    wr(`ADDR_IRQ_MASK, 8'h0f);
    chk(irq_o, 1);
    wr(`ADDR_IRQ_STATUS, 8'h01);
    m_ep = m_ep | 8'h01;
    for (int e = 0; e < 4; e++) begin
      usb_irq_en_i <= e != 2;
      stack_full_i <= e == 1;
      fire(e);
      @(posedge clk_i);
      m_ep = m_ep | 8'h1 << e;
      rd(`ADDR_EP_STATUS, m_ep);
      chk(irq_o, e == 0 || e == 3);
      fire(e);
      wr(`ADDR_EP_STATUS, m_ep & ~(8'h1 << e));
      rd(`ADDR_EP_STATUS, m_ep);
      m_ep = m_ep & ~(8'h1 << e);
      wr(`ADDR_EP_STATUS, m_ep);
      rd(`ADDR_EP_STATUS, m_ep);
      rd(`ADDR_IRQ_STATUS, 8'h1 << e);
      wr(`ADDR_IRQ_STATUS, 8'hff);
      chk(irq_o, 0);
    end
    finish_test;
  end
endmodule // testbench
bind usb_status_and_clock_control_regs usb_regs_props chk_u (.*);
`default_nettype wire

// *** tb/usb_regs_props.sv ***
// assertions on the register bank ports
`include "usb_ctl_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module usb_regs_props (
  // clock, reset, bus
  input wire logic              clk_i,
  input wire logic              resetn_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [7:0]        wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [7:0]        rdata_o,
  // interrupt and controls
  input wire logic              usb_irq_en_i,
  input wire logic              stack_full_i,
  input wire logic              irq_o,
  input wire logic              data_plus_pin_oe_o,
  input wire logic              pullup_swap_ctl_o,
  input wire logic              bus_clock_gate_o,
  input wire logic              bandgap_shutdown_o,
  input wire logic              clk_adjust_disable_o
);
  // ==========
  // sequences
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence clk_wr; wr_i && addr_i == `ADDR_CLK_CTRL; endsequence
  sequence clk_rd; rd_i && addr_i == `ADDR_CLK_CTRL; endsequence
  sequence ep_wr; wr_i && addr_i == `ADDR_EP_STATUS; endsequence
  sequence ep_rd; rd_i && addr_i == `ADDR_EP_STATUS; endsequence
  // ==========
  // properties
  swap_bit_a:
    assert property (clk_wr |=> pullup_swap_ctl_o == $past(wdata_i[2]))
    else $error("swap bit wrong");
  clk_gate_a:
    assert property (clk_wr |=> bus_clock_gate_o == $past(wdata_i[3]))
    else $error("clock gate wrong");
  bandgap_off_a:
    assert property (clk_wr |=> bandgap_shutdown_o == $past(wdata_i[4]))
    else $error("bandgap bit wrong");
  adj_disable_a:
    assert property (clk_wr |=> clk_adjust_disable_o == $past(wdata_i[7]))
    else $error("adjust bit wrong");
  pin_drive_a:
    assert property (ep_wr |=>
      data_plus_pin_oe_o == ($past(wdata_i[5:4]) != `MODE_USB))
    else $error("pin drive wrong");
  clk_resv_a:
    assert property (clk_rd |=> rdata_o[1:0] == 2'h0)
    else $error("reserved clock bits set");
  ep_resv_a:
    assert property (ep_rd |=> !rdata_o[6])
    else $error("reserved endpoint bit set");
  irq_gate_a:
    assert property (irq_o |-> usb_irq_en_i && !stack_full_i)
    else $error("irq while gated");
endmodule // usb_regs_props
`default_nettype wire
